// ==== pkg/cmbm_pkg.sv ====
package cmbm_pkg;
	// Buffer counts and layout
	localparam int N_TX = 3;
	localparam int N_RX = 5;
	localparam int TX_FRAME_BYTES = 13;
	localparam int RX_FRAME_BYTES = 15;
	localparam int BUF_WORDS = 4;
	localparam int MEM_DEPTH = (N_TX + N_RX) * BUF_WORDS;
	localparam int MEM_AW = $clog2(MEM_DEPTH);
	localparam int DW = 32;
	localparam logic [2:0] RX_DEPTH = 3'h5;
	localparam logic [2:0] RX_BUF_BASE = 3'h3;
	// Word 3 of every buffer: length code, local priority, time stamp
	localparam logic [1:0] WORD_META = 2'h3;
	localparam int W3_LOCAL_PRIORITY_FIELD_LSB = 16;
	localparam int W3_TS_LSB = 0;
	localparam int LOCAL_PRIORITY_FIELD_STRB = 2;
	localparam logic [3:0] BE_TS = 4'h3;
	localparam logic [3:0] BE_ALL = 4'hf;
	// APB byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX_FLAG = 8'h04;
	localparam logic [7:0] OFS_TX_SEL = 8'h08;
	localparam logic [7:0] OFS_ABORT_REQ = 8'h0c;
	localparam logic [7:0] OFS_ABORT_ACK = 8'h10;
	localparam logic [7:0] OFS_RX_FLAG = 8'h14;
	localparam logic [3:0] WIN_TX_PAGE = 4'h2;
	localparam logic [3:0] WIN_RX_PAGE = 4'h3;
	// Control register fields
	localparam int CTRL_W = 5;
	localparam int CTRL_LOOPBACK = 0;
	localparam int CTRL_TIME_EN = 1;
	localparam int CTRL_TX_IE = 2;
	localparam int CTRL_RX_IE = 3;
	localparam int CTRL_OVR_IE = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	// Receive flag register fields
	localparam int RXF_FULL_BIT = 0;
	localparam int RXF_OVR_BIT = 1;
	localparam int RXF_CNT_LSB = 4;
	localparam logic [31:0] APB_ZERO = 32'h0000_0000;
endpackage : cmbm_pkg

// ==== pkg/cmbm_mem_if.sv ====
`timescale 1ns/100ps
interface cmbm_mem_if #(parameter int AW = 5, parameter int DW = 32);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW/8-1:0] wr_be;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] a_addr;
	logic [DW-1:0] a_data;
	logic [AW-1:0] b_addr;
	logic [DW-1:0] b_data;
	modport ctrl (output wr_en, wr_addr, wr_be, wr_data, a_addr, b_addr, input a_data, b_data);
	modport mem (input wr_en, wr_addr, wr_be, wr_data, a_addr, b_addr, output a_data, b_data);
endinterface : cmbm_mem_if

// ==== design/cmbm_mem.sv ====
`timescale 1ns/100ps
module cmbm_mem #(
	parameter int DW = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic srst,
	cmbm_mem_if.mem m
);
	genvar g;
	// One byte lane per loop pass, registered read on both ports
	for (g = 0; g < DW / 8; g++)
	begin : g_lane
		logic [7:0] lane_ram [DEPTH];
		logic [7:0] a_q;
		logic [7:0] b_q;
		always_ff @(posedge clk)
		begin
			if (m.wr_en && m.wr_be[g])
			begin
				lane_ram[m.wr_addr] <= m.wr_data[8*g +: 8];
			end
		end
		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				a_q <= 8'h00;
				b_q <= 8'h00;
			end
			else
			begin
				a_q <= lane_ram[m.a_addr];
				b_q <= lane_ram[m.b_addr];
			end
		end
		assign m.a_data[8*g +: 8] = a_q;
		assign m.b_data[8*g +: 8] = b_q;
	end
endmodule : cmbm_mem

// ==== design/cmbm_top.sv ====
// The address map and register access over APB were left to the implementer.
`timescale 1ns/100ps
// How it works
// - Three transmit buffers: frame, priority, stamp
// - Sent frame sets empty flag, transmit interrupt
// - Lowest priority value wins transmit arbitration
// - Priority tie goes to lower buffer index
// - Reprioritise at every arbitration, also retries
// - Abort idle buffer: ack, empty, interrupt
// - Abort ack shows aborted one, sent zero
// - Five-slot receive FIFO, only foreground visible
// - Receive buffer holds fifteen frame bytes
// - Receive full means foreground holds accepted frame
// - Valid accepted frame queued, flag, interrupt
// - Next frame received straight after interframe
// - Invalid frames never enter the FIFO
// - Own frames not queued nor acknowledged
// - Loopback treats own frames like others
// - Lost arbitration switches straight to receiving
// - Frame into full FIFO dropped, overrun flagged
// - Full FIFO keeps transmitting, resumes when freed
// - Stamp timer into active buffer on acknowledge
module cmbm_top
	import cmbm_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic arb_req,
	output logic tx_pending,
	output logic [1:0] tx_buf_idx,
	input wire logic [1:0] tx_rd_word,
	output logic [31:0] tx_rd_data,
	input wire logic tx_done,
	input wire logic tx_lost,
	input wire logic tx_error,
	input wire logic rx_wr_valid,
	input wire logic [1:0] rx_wr_word,
	input wire logic [31:0] rx_wr_data,
	input wire logic rx_frame_end,
	input wire logic rx_frame_ok,
	input wire logic rx_frame_own,
	input wire logic bus_ack,
	input wire logic [15:0] ts_timer,
	output logic own_ack_inhibit,
	output logic tx_int,
	output logic rx_int,
	output logic err_int
);
	cmbm_mem_if #(.AW(MEM_AW), .DW(DW)) mem_bus ();

	logic [CTRL_W-1:0] ctrl_reg;
	logic [N_TX-1:0] tx_empty_reg;
	logic [N_TX-1:0] tx_sel_reg;
	logic [N_TX-1:0] abort_req_reg;
	logic [N_TX-1:0] abort_ack_reg;
	logic [7:0] local_priority_field_reg [N_TX];
	logic tx_active_reg;
	logic [1:0] tx_cur_reg;
	logic [2:0] rx_wr_ptr_reg;
	logic [2:0] rx_rd_ptr_reg;
	logic [2:0] rx_count_reg;
	logic overrun_reg;

	logic acc;
	logic wr_fire;
	logic win_tx;
	logic win_rx;
	logic [1:0] win_word;
	logic [1:0] sel_idx;
	logic tx_win_ok;
	logic reg_hit;
	logic [N_TX-1:0] pend;
	logic [1:0] best;
	logic rx_full;
	logic rx_bg_free;
	logic frame_keep;
	logic push;
	logic pop;
	logic ovr_evt;
	logic ts_wr;
	logic eng_wr;
	logic apb_mem_wr;

	function automatic logic [1:0] first_idx(input logic [N_TX-1:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = N_TX - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = 2'(i);
			end
		end
		return r;
	endfunction : first_idx

	function automatic logic [2:0] ptr_inc(input logic [2:0] p);
		return (p == RX_DEPTH - 3'h1) ? 3'h0 : p + 3'h1;
	endfunction : ptr_inc

	cmbm_mem #(.DW(DW), .DEPTH(MEM_DEPTH)) u_mem (
		.clk(clk),
		.srst(srst),
		.m(mem_bus.mem)
	);

	// APB decode
	assign acc = psel && penable;
	assign wr_fire = acc && pwrite && pready;
	assign win_tx = paddr[7:4] == WIN_TX_PAGE;
	assign win_rx = paddr[7:4] == WIN_RX_PAGE;
	assign win_word = paddr[3:2];
	assign sel_idx = first_idx(tx_sel_reg);
	assign tx_win_ok = (|tx_sel_reg) && tx_empty_reg[sel_idx];
	assign rx_full = rx_count_reg != 3'h0;
	assign reg_hit = paddr == OFS_CTRL || paddr == OFS_TX_FLAG || paddr == OFS_TX_SEL
		|| paddr == OFS_ABORT_REQ || paddr == OFS_ABORT_ACK || paddr == OFS_RX_FLAG;
	assign pslverr = acc && !(reg_hit || win_tx || win_rx);

	// Memory write arbitration: stamp, then engine, then host
	assign ts_wr = bus_ack && ctrl_reg[CTRL_TIME_EN] && (tx_active_reg || rx_bg_free);
	assign eng_wr = rx_wr_valid && rx_bg_free;
	assign apb_mem_wr = acc && pwrite && win_tx && tx_win_ok;
	assign pready = !(apb_mem_wr && (ts_wr || eng_wr));

	always_comb
	begin
		mem_bus.wr_en = ts_wr || eng_wr || apb_mem_wr;
		mem_bus.wr_be = pstrb;
		mem_bus.wr_data = pwdata;
		mem_bus.wr_addr = {1'b0, sel_idx, win_word};
		if (ts_wr)
		begin
			mem_bus.wr_be = BE_TS;
			mem_bus.wr_data = APB_ZERO;
			mem_bus.wr_data[W3_TS_LSB +: 16] = ts_timer;
			mem_bus.wr_addr = tx_active_reg ? {1'b0, tx_cur_reg, WORD_META}
				: {3'(RX_BUF_BASE + rx_wr_ptr_reg), WORD_META};
		end
		else if (eng_wr)
		begin
			mem_bus.wr_be = BE_ALL;
			mem_bus.wr_data = rx_wr_data;
			mem_bus.wr_addr = {3'(RX_BUF_BASE + rx_wr_ptr_reg), rx_wr_word};
		end
	end

	// Port A serves the host windows, port B the frame engine
	assign mem_bus.a_addr = win_rx ? {3'(RX_BUF_BASE + rx_rd_ptr_reg), win_word}
		: {1'b0, sel_idx, win_word};
	assign mem_bus.b_addr = {1'b0, tx_cur_reg, tx_rd_word};
	assign tx_rd_data = mem_bus.b_data;

	always_comb
	begin
		prdata = APB_ZERO;
		if (acc && !pwrite)
		begin
			case (paddr)
				OFS_CTRL: prdata[CTRL_W-1:0] = ctrl_reg;
				OFS_TX_FLAG: prdata[N_TX-1:0] = tx_empty_reg;
				OFS_TX_SEL: prdata[N_TX-1:0] = tx_sel_reg;
				OFS_ABORT_REQ: prdata[N_TX-1:0] = abort_req_reg;
				OFS_ABORT_ACK: prdata[N_TX-1:0] = abort_ack_reg;
				OFS_RX_FLAG:
				begin
					prdata[RXF_FULL_BIT] = rx_full;
					prdata[RXF_OVR_BIT] = overrun_reg;
					prdata[RXF_CNT_LSB +: 3] = rx_count_reg;
				end
				default:
				begin
					if ((win_tx && tx_win_ok) || (win_rx && rx_full))
					begin
						prdata = mem_bus.a_data;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_reg <= CTRL_RESET;
		end
		else if (wr_fire && paddr == OFS_CTRL)
		begin
			ctrl_reg <= pwdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_sel_reg <= '0;
		end
		else if (wr_fire && paddr == OFS_TX_SEL)
		begin
			tx_sel_reg <= (pwdata[N_TX-1:0] & tx_empty_reg)
				& (~(pwdata[N_TX-1:0] & tx_empty_reg) + {{(N_TX-1){1'b0}}, 1'b1});
		end
	end

	// Transmit arbitration: downward scan with less-or-equal hands a tie to the lower index
	assign pend = ~tx_empty_reg & ~abort_req_reg;
	always_comb
	begin
		best = 2'h0;
		for (int i = N_TX - 1; i >= 0; i--)
		begin
			if (pend[i] && (!pend[best] || best > 2'(i) || local_priority_field_reg[i] < local_priority_field_reg[best]))
			begin
				if (!pend[best] || local_priority_field_reg[i] <= local_priority_field_reg[best])
				begin
					best = 2'(i);
				end
			end
		end
	end
	assign tx_pending = (|pend) && !tx_active_reg;
	assign tx_buf_idx = tx_cur_reg;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_active_reg <= 1'b0;
			tx_cur_reg <= 2'h0;
		end
		else if (!tx_active_reg && arb_req && (|pend))
		begin
			tx_active_reg <= 1'b1;
			tx_cur_reg <= best;
		end
		else if (tx_done || tx_lost || tx_error)
		begin
			tx_active_reg <= 1'b0;
		end
	end

	// Per buffer flags; hardware update wins over host write
	genvar gi;
	for (gi = 0; gi < N_TX; gi++)
	begin : g_tx
		logic busy;
		logic sent;
		logic grant;
		logic host_clr;
		assign busy = tx_active_reg && tx_cur_reg == 2'(gi);
		assign sent = busy && tx_done;
		assign grant = abort_req_reg[gi] && !tx_empty_reg[gi] && !busy;
		assign host_clr = wr_fire && paddr == OFS_TX_FLAG && pwdata[gi];
		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				tx_empty_reg[gi] <= 1'b1;
			end
			else if (sent || grant)
			begin
				tx_empty_reg[gi] <= 1'b1;
			end
			else if (host_clr)
			begin
				tx_empty_reg[gi] <= 1'b0;
			end
		end
		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				abort_ack_reg[gi] <= 1'b0;
			end
			else if (grant)
			begin
				abort_ack_reg[gi] <= 1'b1;
			end
			else if (sent || host_clr)
			begin
				abort_ack_reg[gi] <= 1'b0;
			end
		end
		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				abort_req_reg[gi] <= 1'b0;
			end
			else if (grant || sent)
			begin
				abort_req_reg[gi] <= 1'b0;
			end
			else if (wr_fire && paddr == OFS_ABORT_REQ && pwdata[gi] && !tx_empty_reg[gi])
			begin
				abort_req_reg[gi] <= 1'b1;
			end
		end
		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				local_priority_field_reg[gi] <= 8'h00;
			end
			else if (apb_mem_wr && pready && sel_idx == 2'(gi) && win_word == WORD_META
				&& pstrb[LOCAL_PRIORITY_FIELD_STRB])
			begin
				local_priority_field_reg[gi] <= pwdata[W3_LOCAL_PRIORITY_FIELD_LSB +: 8];
			end
		end
	end

	// Receive FIFO
	assign rx_bg_free = rx_count_reg < RX_DEPTH;
	assign frame_keep = rx_frame_end && rx_frame_ok
		&& (!rx_frame_own || ctrl_reg[CTRL_LOOPBACK]);
	assign push = frame_keep && rx_bg_free;
	assign ovr_evt = frame_keep && !rx_bg_free;
	assign pop = wr_fire && paddr == OFS_RX_FLAG && pwdata[RXF_FULL_BIT] && rx_full;
	assign own_ack_inhibit = tx_active_reg && !ctrl_reg[CTRL_LOOPBACK];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx_wr_ptr_reg <= 3'h0;
			rx_rd_ptr_reg <= 3'h0;
		end
		else
		begin
			if (push)
			begin
				rx_wr_ptr_reg <= ptr_inc(rx_wr_ptr_reg);
			end
			if (pop)
			begin
				rx_rd_ptr_reg <= ptr_inc(rx_rd_ptr_reg);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx_count_reg <= 3'h0;
		end
		else if (push && !pop)
		begin
			rx_count_reg <= rx_count_reg + 3'h1;
		end
		else if (pop && !push)
		begin
			rx_count_reg <= rx_count_reg - 3'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			overrun_reg <= 1'b0;
		end
		else if (ovr_evt)
		begin
			overrun_reg <= 1'b1;
		end
		else if (wr_fire && paddr == OFS_RX_FLAG && pwdata[RXF_OVR_BIT])
		begin
			overrun_reg <= 1'b0;
		end
	end

	assign tx_int = (|tx_empty_reg) && ctrl_reg[CTRL_TX_IE];
	assign rx_int = rx_full && ctrl_reg[CTRL_RX_IE];
	assign err_int = overrun_reg && ctrl_reg[CTRL_OVR_IE];

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_sent;
		tx_active_reg && tx_done;
	endsequence
	sequence s_abort_on_air0;
		tx_active_reg && tx_cur_reg == 2'h0 && abort_req_reg[0] && tx_lost;
	endsequence
	property p_sent_release;
		s_sent |=> tx_empty_reg[$past(tx_cur_reg)] && !abort_ack_reg[$past(tx_cur_reg)];
	endproperty
	a_sent_release: assert property (p_sent_release) else $error("sent buffer not released");
	property p_tie_low_index;
		!tx_active_reg && arb_req && pend[0] && pend[1] && local_priority_field_reg[0] <= local_priority_field_reg[1]
			|=> tx_active_reg && tx_cur_reg != 2'h1;
	endproperty
	a_tie_low_index: assert property (p_tie_low_index) else $error("tie lost by index");
	property p_lowest_wins;
		!tx_active_reg && arb_req && pend[2] && local_priority_field_reg[2] < local_priority_field_reg[0]
			&& local_priority_field_reg[2] < local_priority_field_reg[1] |=> tx_cur_reg == 2'h2;
	endproperty
	a_lowest_wins: assert property (p_lowest_wins) else $error("lowest priority lost");
	property p_retry_pending;
		tx_active_reg && tx_error |=> !tx_active_reg && !tx_empty_reg[$past(tx_cur_reg)];
	endproperty
	a_retry_pending: assert property (p_retry_pending) else $error("retry buffer dropped");
	property p_no_abort_on_air;
		$rose(abort_ack_reg[0]) |-> !$past(tx_active_reg && tx_cur_reg == 2'h0) && tx_empty_reg[0];
	endproperty
	a_no_abort_on_air: assert property (p_no_abort_on_air) else $error("abort on air");
	property p_abort_after_tx;
		s_abort_on_air0 |-> ##2 abort_ack_reg[0] && tx_empty_reg[0];
	endproperty
	a_abort_after_tx: assert property (p_abort_after_tx) else $error("late abort lost");
	property p_refill_fg;
		pop && !push && rx_count_reg > 3'h1 |=> rx_full && rx_count_reg == $past(rx_count_reg) - 3'h1;
	endproperty
	a_refill_fg: assert property (p_refill_fg) else $error("foreground not refilled");
	property p_overrun;
		ovr_evt && !pop |=> overrun_reg && rx_count_reg == RX_DEPTH;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun mishandled");
	property p_own_dropped;
		rx_frame_end && rx_frame_own && !ctrl_reg[CTRL_LOOPBACK] && !pop |=> $stable(rx_count_reg);
	endproperty
	a_own_dropped: assert property (p_own_dropped) else $error("own frame queued");
	property p_loop_own_kept;
		rx_frame_end && rx_frame_ok && rx_frame_own && ctrl_reg[CTRL_LOOPBACK] && rx_bg_free && !pop
			|=> rx_count_reg == $past(rx_count_reg) + 3'h1;
	endproperty
	a_loop_own_kept: assert property (p_loop_own_kept) else $error("loopback frame lost");
	property p_stamp;
		bus_ack && ctrl_reg[CTRL_TIME_EN] && tx_active_reg
			|-> mem_bus.wr_en && mem_bus.wr_be == BE_TS && mem_bus.wr_addr[1:0] == WORD_META;
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp not written");
endmodule : cmbm_top

// ==== tb/cmbm_engine_model.sv ====
`timescale 1ns/100ps
// Protocol engine and bus side stand-in
module cmbm_engine_model (
	input wire logic clk,
	output logic arb_req,
	output logic [1:0] tx_rd_word,
	output logic tx_done,
	output logic tx_lost,
	output logic tx_error,
	output logic rx_wr_valid,
	output logic [1:0] rx_wr_word,
	output logic [31:0] rx_wr_data,
	output logic rx_frame_end,
	output logic rx_frame_ok,
	output logic rx_frame_own,
	output logic bus_ack,
	output logic [15:0] ts_timer
);
	initial
	begin
		{arb_req, tx_rd_word, tx_done, tx_lost, tx_error, bus_ack, ts_timer} = '0;
		{rx_wr_valid, rx_wr_word, rx_wr_data, rx_frame_end, rx_frame_ok, rx_frame_own} = '0;
	end
	// Result 0 sent, 1 lost, 2 bus error; gap sets how slowly it arbitrates
	task automatic transmit(input int res, input int gap, input logic [15:0] stamp);
		int i;
		repeat (gap) @(posedge clk);
		arb_req <= 1'b1;
		@(posedge clk);
		arb_req <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			tx_rd_word <= i[1:0];
			@(posedge clk);
		end
		bus_ack <= (res == 0);
		ts_timer <= stamp;
		@(posedge clk);
		bus_ack <= 1'b0;
		ts_timer <= ~stamp;
		tx_done <= (res == 0);
		tx_lost <= (res == 1);
		tx_error <= (res == 2);
		@(posedge clk);
		{tx_done, tx_lost, tx_error} <= 3'b000;
	endtask : transmit
	// Four words then the verdict; released lines carry inverted values
	task automatic receive(input logic ok, input logic own, input logic [31:0] d);
		int i;
		for (i = 0; i < 4; i++)
		begin
			rx_wr_valid <= 1'b1;
			rx_wr_word <= i[1:0];
			rx_wr_data <= d + 32'(i);
			@(posedge clk);
		end
		rx_wr_valid <= 1'b0;
		rx_wr_data <= ~(d + 32'h0000_0003);
		rx_frame_end <= 1'b1;
		rx_frame_ok <= ok;
		rx_frame_own <= own;
		@(posedge clk);
		rx_frame_end <= 1'b0;
		rx_frame_ok <= ~ok;
		rx_frame_own <= ~own;
	endtask : receive
endmodule : cmbm_engine_model

// ==== tb/cmbm_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cmbm_top_tb
	import cmbm_pkg::*;
;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, tx_pending, own_ack_inhibit;
	logic tx_int, rx_int, err_int, arb_req, tx_done, tx_lost, tx_error, rx_wr_valid;
	logic rx_frame_end, rx_frame_ok, rx_frame_own, bus_ack;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, tx_rd_data, rx_wr_data, rnd;
	logic [3:0] pstrb;
	logic [1:0] tx_buf_idx, tx_rd_word, rx_wr_word;
	logic [15:0] ts_timer;
	logic [32:0] expq[$];
	logic [32:0] e;
	logic [31:0] fr[8];
	logic [31:0] txw;
	int errors = 0;
	int checked = 0;
	int i;
	cmbm_top uut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .arb_req, .tx_pending, .tx_buf_idx, .tx_rd_word, .tx_rd_data,
		.tx_done, .tx_lost, .tx_error, .rx_wr_valid, .rx_wr_word, .rx_wr_data, .rx_frame_end,
		.rx_frame_ok, .rx_frame_own, .bus_ack, .ts_timer, .own_ack_inhibit, .tx_int, .rx_int,
		.err_int);
	cmbm_engine_model eng (.clk, .arb_req, .tx_rd_word, .tx_done, .tx_lost, .tx_error,
		.rx_wr_valid, .rx_wr_word, .rx_wr_data, .rx_frame_end, .rx_frame_ok, .rx_frame_own,
		.bus_ack, .ts_timer);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Read results settle by the falling edge before the completing edge
	always @(negedge clk)
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			e = expq.pop_front();
			`CHK({pslverr, prdata}, e)
		end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic report_and_stop;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// One transfer, then an idle cycle so strobes are never reassigned in one step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] x);
		int n;
		logic rdy;
		if (!wr)
			expq.push_back(x);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		rdy = 1'b0;
		while (!rdy)
		begin
			@(negedge clk);
			rdy = (pready === 1'b1);
			@(posedge clk);
			n++;
			if (n > 50)
			begin
				errors++;
				report_and_stop();
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, APB_ZERO, {1'b0, x});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {1'b0, APB_ZERO});
	endtask : wr
	// Side outputs checked while idle: index, pending, inhibit, three interrupts
	task automatic outs(input logic [6:0] x);
		@(negedge clk);
		`CHK({tx_buf_idx, tx_pending, own_ack_inhibit, tx_int, rx_int, err_int}, x)
		@(posedge clk);
	endtask : outs
	task automatic load(input int k, input logic [7:0] local_priority_field);
		int w;
		wr(OFS_TX_SEL, 32'(1 << k));
		for (w = 0; w < 3; w++)
		begin
			rnd = lfsr(rnd);
			if (w == 0)
				txw = rnd;
			wr({WIN_TX_PAGE, w[1:0], 2'b00}, rnd);
		end
		wr({WIN_TX_PAGE, 4'hc}, {8'h08, local_priority_field, 16'h0000});
		wr(OFS_TX_FLAG, 32'(1 << k));
	endtask : load
	task automatic frame(input int k, input logic ok, input logic own);
		rnd = lfsr(rnd);
		fr[k] = rnd;
		eng.receive(ok, own, rnd);
	endtask : frame
	initial
	begin
		{srst, psel, penable, pwrite, paddr, pwdata} = {3'b100, 1'b0, 8'h00, APB_ZERO};
		pstrb = 4'hf;
		rnd = 32'he916_2ddf;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		outs(7'h00);
		rd(OFS_TX_FLAG, 32'h0000_0007);
		rd(OFS_ABORT_ACK, APB_ZERO);
		rd(OFS_RX_FLAG, APB_ZERO);
		apb(1'b0, 8'h18, APB_ZERO, 33'h1_0000_0000);
		$display("test reset done");
		load(0, 8'h04);
		load(1, 8'h04);
		rd(OFS_TX_FLAG, 32'h0000_0004);
		outs(7'h10);
		eng.transmit(2, 1, 16'h0000);
		load(2, 8'h01);
		fork
			eng.transmit(0, 5, 16'h0000);
			begin
				repeat (7) @(posedge clk);
				@(negedge clk);
				`CHK(tx_rd_data, txw)
			end
		join
		rd(OFS_TX_FLAG, 32'h0000_0004);
		outs(7'h50);
		eng.transmit(0, 1, 16'h0000);
		rd(OFS_TX_FLAG, 32'h0000_0005);
		eng.transmit(1, 1, 16'h0000);
		frame(0, 1'b1, 1'b0);
		rd(OFS_TX_FLAG, 32'h0000_0005);
		rd(OFS_RX_FLAG, 32'h0000_0011);
		wr(OFS_CTRL, 32'h0000_0002);
		eng.transmit(0, 1, 16'h3c5a);
		rd(OFS_TX_FLAG, 32'h0000_0007);
		rd(OFS_ABORT_ACK, APB_ZERO);
		wr(OFS_TX_SEL, 32'h0000_0002);
		rd({WIN_TX_PAGE, 4'hc}, 32'h0804_3c5a);
		wr(OFS_CTRL, APB_ZERO);
		$display("test priority done");
		load(0, 8'h00);
		load(1, 8'h02);
		fork
			eng.transmit(0, 1, 16'h0000);
			begin
				repeat (3) @(posedge clk);
				wr(OFS_ABORT_REQ, 32'h0000_0003);
				outs(7'h08);
			end
		join
		rd(OFS_ABORT_ACK, 32'h0000_0002);
		rd(OFS_TX_FLAG, 32'h0000_0007);
		load(0, 8'h00);
		fork
			eng.transmit(1, 1, 16'h0000);
			begin
				repeat (3) @(posedge clk);
				wr(OFS_ABORT_REQ, 32'h0000_0001);
			end
		join
		rd(OFS_ABORT_ACK, 32'h0000_0003);
		rd(OFS_TX_FLAG, 32'h0000_0007);
		$display("test abort done");
		frame(1, 1'b0, 1'b0);
		rd(OFS_RX_FLAG, 32'h0000_0011);
		frame(1, 1'b1, 1'b1);
		rd(OFS_RX_FLAG, 32'h0000_0011);
		for (i = 0; i < 4; i++)
			rd({WIN_RX_PAGE, i[1:0], 2'b00}, fr[0] + 32'(i));
		wr(OFS_CTRL, 32'h0000_0001);
		frame(1, 1'b1, 1'b1);
		wr(OFS_CTRL, APB_ZERO);
		rd(OFS_RX_FLAG, 32'h0000_0021);
		for (i = 2; i < 6; i++)
			frame(i, 1'b1, 1'b0);
		rd(OFS_RX_FLAG, 32'h0000_0053);
		wr(OFS_CTRL, 32'h0000_001c);
		outs(7'h07);
		load(0, 8'h00);
		eng.transmit(0, 1, 16'h0000);
		rd(OFS_TX_FLAG, 32'h0000_0007);
		wr(OFS_RX_FLAG, 32'h0000_0003);
		rd(OFS_RX_FLAG, 32'h0000_0041);
		rd({WIN_RX_PAGE, 4'h0}, fr[1]);
		frame(6, 1'b1, 1'b0);
		rd(OFS_RX_FLAG, 32'h0000_0051);
		$display("test receive done");
		report_and_stop();
	end
endmodule : cmbm_top_tb
